// *** dv/link_partner_model.sv ***
`timescale 1ns/100ps
module link_partner_model (
	// Link clock.
	input wire logic link_clk,
	// Status toward the device.
	output logic neg_page_rx_pulse,
	output logic neg_done_in,
	output logic rx_pkt_active,
	output logic descrambler_locked,
	output logic link_qualified
);
	initial begin
		neg_page_rx_pulse = 0;
		neg_done_in = 0;
		rx_pkt_active = 0;
		descrambler_locked = 1;
		link_qualified = 0;
	end
	task page;
		@(posedge link_clk) neg_page_rx_pulse <= 1;
		@(posedge link_clk) neg_page_rx_pulse <= 0;
	endtask
	task pkt(input int n);
		@(posedge link_clk) rx_pkt_active <= 1;
		repeat (n) @(posedge link_clk);
		rx_pkt_active <= 0;
	endtask
	task done(input logic d);
		@(posedge link_clk) neg_done_in <= d;
	endtask
	task unlock;
		@(posedge link_clk) descrambler_locked <= 0;
		@(posedge link_clk) descrambler_locked <= 1;
	endtask
endmodule // link_partner_model

// *** dv/phy_mac_if_regs_sva.sv ***
`timescale 1ns/100ps
module phy_mac_if_regs_sva
	import phy_mac_if_pkg::*;
(
	// Clock and bus.
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [31:0] awaddr,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic [31:0] rdata,
	input wire logic rvalid,
	// Datapath side.
	input wire logic speed_10_100,
	input wire phy_mac_if_pkg::phy_cfg_t cfg
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence wr_s(a);
		awvalid && awready && wvalid && wready && awaddr == a && wstrb[0];
	endsequence
	property set_p(a, b, f);
		logic v;
		(wr_s(a), v = wdata[b]) |-> ##3 f == v;
	endproperty
	AST_TX: assert property (set_p(32'hc8, 1, cfg.tx_clk_shift_en))
		else $error("tx shift missed write");
	AST_SKIP: assert property (set_p(32'hcc, 4, cfg.async_fifo_skip_en))
		else $error("fifo skip missed write");
	AST_EDV: assert property (set_p(32'h10c, 0, cfg.early_rx_valid_en))
		else $error("early valid missed write");
	AST_DLY: assert property (cfg.async_fifo_skip_clock_delay_en && $past(speed_10_100)
		|-> cfg.rx_clk_shift_en) else $error("rx clock not delayed");
	AST_LAT: assert property (cfg.low_latency_active |-> $past(speed_10_100))
		else $error("low latency outside 10/100");
	AST_RSV: assert property (rvalid |-> rdata[31:16] == 16'h0)
		else $error("upper read bits set");
	AST_ABT: assert property (cfg.rx_abort |-> !cfg.descrambler_limit_off)
		else $error("abort with limit off");
	AST_REC: assert property (cfg.descrambler_recovering |-> cfg.descrambler_recovery_ms != 4'h0)
		else $error("recovery with zero time");
	AST_RST: assert property ($rose(aresetn) |-> cfg.enhanced_ternary_detect_en
		&& cfg.descrambler_recovery_ms == 4'hf) else $error("bad cfg reset");
endmodule // phy_mac_if_regs_sva

bind phy_mac_if_regs phy_mac_if_regs_sva u_sva (.aclk(aclk), .aresetn(aresetn),
	.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
	.wvalid(wvalid), .wready(wready), .rdata(rdata), .rvalid(rvalid),
	.speed_10_100(speed_10_100), .cfg(cfg));

// *** dv/tb_phy_mac_if_and_fast_rx_config.sv ***
`timescale 1ns/100ps
module tb_phy_mac_if_and_fast_rx_config;
	import phy_mac_if_pkg::*;
	typedef struct {logic [31:0] a, d, e; logic [1:0] r;} row_t;
	logic aclk = 0, aresetn = 0, link_clk = 0, link_rstn = 0, speed_10_100 = 1;
	logic [31:0] awaddr = 0, wdata = 0, araddr = 0, v;
	logic [3:0] wstrb = 0;
	logic [1:0] r;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic neg_page_rx_pulse, neg_done_in, rx_pkt_active, descrambler_locked, link_qualified;
	phy_cfg_t cfg;
	int err_count = 0, n_tests = 0, cyc = 0, ab_n = 0, rc_n = 0, ab0 = 0, rc0 = 0;
	row_t rows[6] = '{'{32'hc8, 32'h3, 32'h3, 2'h0}, '{32'hcc, 32'hffff, 32'h1c, 2'h0},
		'{32'h10c, 32'hffff, 32'hff7, 2'h0}, '{32'hdc, 32'hffff, 32'h0, 2'h0},
		'{32'h100, 32'h5, 32'h0, 2'h3}, '{32'h10c, 32'h0, 32'h0, 2'h0}};
	always #4 aclk = ~aclk;
	initial begin
		#13;
		forever #80 link_clk = ~link_clk;
	end
	phy_mac_if_regs #(.PKT_LIMIT_CYC(50), .MS_CYC(10)) dut (.aclk, .aresetn, .awaddr, .awvalid,
		.awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
		.arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .link_clk, .link_rstn,
		.neg_page_rx_pulse, .neg_done_in, .rx_pkt_active, .descrambler_locked,
		.link_qualified, .speed_10_100, .cfg);
	link_partner_model link (.link_clk, .neg_page_rx_pulse, .neg_done_in, .rx_pkt_active,
		.descrambler_locked, .link_qualified);
	task give_verdict;
		$display("tests %0d errors %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	always @(posedge aclk) begin
		cyc++;
		if (cfg.rx_abort === 1'b1) ab_n++;
		if (cfg.descrambler_recovering === 1'b1) rc_n++;
		if (cyc == 20000) begin
			err_count++;
			give_verdict;
		end
	end
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED %s exp %h got %h", nm, e, g);
		end
	endtask
	task w(input int n);
		repeat (n) @(posedge aclk);
	endtask
	// Address and data channels are released at the edge where their own ready is seen, the response channel at the edge where bvalid is seen.
	task wr(input logic [31:0] a, d);
		@(posedge aclk);
		{awaddr, wdata, wstrb} <= {a, d, 4'hf};
		{awvalid, wvalid, bready} <= 3'h7;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
			if (bvalid) begin
				r = bresp;
				bready <= 0;
			end
		end while (awvalid || wvalid || bready);
	endtask
	task rd(input logic [31:0] a);
		@(posedge aclk);
		araddr <= a;
		{arvalid, rready} <= 2'h3;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 0;
			if (rvalid) begin
				{v, r} = {rdata, rresp};
				rready <= 0;
			end
		end while (arvalid || rready);
	endtask
	task rc(input logic [31:0] a, e);
		rd(a);
		chk("rdata", e, v);
	endtask
	initial begin
		w(3);
		aresetn <= 1;
		repeat (3) @(posedge link_clk);
		link_rstn <= 1;
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d);
			chk("bresp", rows[i].r, r);
			rc(rows[i].a, rows[i].e);
			chk("rresp", rows[i].r, r);
		end
		$display("test table done");
		chk("lowlat", 1, cfg.low_latency_active);
		speed_10_100 <= 0;
		wr(32'hc8, 0);
		w(3);
		chk("lowlat", 0, cfg.low_latency_active);
		chk("rxshift", 0, cfg.rx_clk_shift_en);
		wr(32'hc8, 32'h1);
		w(3);
		chk("rxshift", 1, cfg.rx_clk_shift_en);
		wr(32'hc8, 32'h2);
		speed_10_100 <= 1;
		w(3);
		chk("rxshift", 1, cfg.rx_clk_shift_en);
		chk("txshift", 1, cfg.tx_clk_shift_en);
		chk("skip", 1, cfg.async_fifo_skip_en);
		chk("skipdly", 1, cfg.async_fifo_skip_clock_delay_en);
		wr(32'h10c, 32'hffff);
		w(3);
		chk("limoff", 1, cfg.descrambler_limit_off);
		chk("recms", 4'hf, cfg.descrambler_recovery_ms);
		chk("ternary", 1, cfg.enhanced_ternary_detect_en);
		chk("gap", 1, cfg.enhanced_gap_detect_en);
		chk("scram", 1, cfg.scrambler_off);
		chk("odd", 1, cfg.odd_nibble_detect_en);
		chk("edv", 1, cfg.early_rx_valid_en);
		wr(32'h10c, 32'h40);
		w(3);
		chk("good", 1, cfg.good_link_100);
		wr(32'h10c, 0);
		w(3);
		chk("good", 0, cfg.good_link_100);
		$display("test cfg done");
		link.page();
		w(60);
		rc(32'hdc, 32'h2);
		link.done(1);
		w(60);
		rc(32'hdc, 32'h3);
		wr(32'hdc, 0);
		rc(32'hdc, 32'h3);
		$display("test status done");
		ab0 = ab_n;
		link.pkt(2);
		w(30);
		chk("abort", 0, ab_n - ab0);
		link.pkt(5);
		w(30);
		chk("abort", 1, ab_n > ab0);
		wr(32'h10c, 32'h800);
		ab0 = ab_n;
		link.pkt(5);
		w(30);
		chk("abort", 0, ab_n - ab0);
		wr(32'h10c, 32'h100);
		rc0 = rc_n;
		link.unlock();
		w(60);
		chk("recov", 20, rc_n - rc0);
		wr(32'h10c, 0);
		rc0 = rc_n;
		link.unlock();
		w(60);
		chk("recov", 0, rc_n - rc0);
		$display("test link done");
		aresetn <= 0;
		w(3);
		aresetn <= 1;
		w(2);
		chk("ternary", 1, cfg.enhanced_ternary_detect_en);
		rc(32'hc8, 0);
		rc(32'hcc, 0);
		rc(32'hdc, 32'h1);
		rc(32'h10c, 32'h7a0);
		$display("test reset done");
		give_verdict;
	end
endmodule // tb_phy_mac_if_and_fast_rx_config

// *** logic/phy_mac_if_consts.svh ***
`ifndef PHY_MAC_IF_CONSTS_SVH
`define PHY_MAC_IF_CONSTS_SVH

// Register indices; the byte address is four times the index.
`define SKEW_CTRL_IDX 8'h32
`define FIFO_CTRL_IDX 8'h33
`define NEG_STATUS_IDX 8'h37
`define FE_RX_CFG_IDX 8'h43

// Clock skew control fields.
`define SKEW_TX_DELAY_BIT 1
`define SKEW_RX_DELAY_BIT 0
`define SKEW_CTRL_RST 2'h0

// Async FIFO and latency control fields.
`define FIFO_SKIP_BIT 4
`define FIFO_SKIP_DLY_BIT 3
`define FIFO_LOW_LAT_BIT 2
`define FIFO_CTRL_RST 3'h0

// Serial negotiation status fields.
`define NEG_PAGE_BIT 1
`define NEG_DONE_BIT 0

// Fast Ethernet receive configuration fields.
`define FE_LIMIT_OFF_BIT 11
`define FE_RECOV_HI 10
`define FE_RECOV_LO 7
`define FE_FORCE_GOOD_BIT 6
`define FE_TERNARY_BIT 5
`define FE_GAP_BIT 4
`define FE_RSVD_BIT 3
`define FE_SCRAMBLER_OFF_BIT 2
`define FE_ODD_NIBBLE_BIT 1
`define FE_EARLY_DV_BIT 0
`define FE_RX_CFG_RST 12'h7a0

// Timing.
`define CLK_MHZ 125
`define PKT_LIMIT_US 1500
`define MS_US 1000
`define PKT_LIMIT_CYC (`PKT_LIMIT_US * `CLK_MHZ)
`define MS_CYC (`MS_US * `CLK_MHZ)

// Bus responses.
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3

`endif

// *** logic/phy_mac_if_pkg.sv ***
package phy_mac_if_pkg;

	typedef enum {
		SEL_SKEW,
		SEL_FIFO,
		SEL_NEG,
		SEL_FE,
		SEL_NONE
	} reg_sel_t;

	typedef struct packed {
		logic tx_clk_shift_en;
		logic rx_clk_shift_en;
		logic async_fifo_skip_en;
		logic async_fifo_skip_clock_delay_en;
		logic low_latency_active;
		logic descrambler_limit_off;
		logic [3:0] descrambler_recovery_ms;
		logic good_link_100;
		logic enhanced_ternary_detect_en;
		logic enhanced_gap_detect_en;
		logic scrambler_off;
		logic odd_nibble_detect_en;
		logic early_rx_valid_en;
		logic rx_abort;
		logic descrambler_recovering;
	} phy_cfg_t;

	typedef struct packed {
		logic page_rx_tgl;
		logic neg_done;
		logic pkt_active;
		logic desc_locked;
		logic link_ok;
	} link_src_t;

endpackage

// *** logic/phy_mac_if_regs.sv ***
`timescale 1ns/100ps
`include "phy_mac_if_consts.svh"

module phy_mac_if_regs #(
	parameter int unsigned PKT_LIMIT_CYC = `PKT_LIMIT_CYC,
	parameter int unsigned MS_CYC = `MS_CYC
) (
	// System clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite slave.
	input wire logic [31:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [31:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Link-side status, all on link_clk.
	input wire logic link_clk,
	input wire logic link_rstn,
	input wire logic neg_page_rx_pulse,
	input wire logic neg_done_in,
	input wire logic rx_pkt_active,
	input wire logic descrambler_locked,
	input wire logic link_qualified,
	// Speed from logic on aclk: high at 10 or 100 Mbps.
	input wire logic speed_10_100,
	// Datapath configuration.
	output phy_mac_if_pkg::phy_cfg_t cfg
);
	import phy_mac_if_pkg::*;

	typedef struct packed {
		logic awready;
		logic wready;
		logic aw_have;
		logic w_have;
		logic [31:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [1:0] skew;
		logic [2:0] fifo;
		logic [11:0] fe;
		link_src_t sync1;
		link_src_t sync2;
		link_src_t sync3;
		logic [1:0] warm;
		logic page_seen;
		logic [31:0] pkt_cnt;
		logic [31:0] ms_div;
		logic [3:0] ms_left;
		phy_cfg_t cfg;
	} state_t;

	state_t s_r;
	state_t s_nxt;
	link_src_t l_r;
	link_src_t l_nxt;

	function automatic reg_sel_t decode(input logic [31:0] addr);
		logic [31:0] idx;
		idx = {2'h0, addr[31:2]};
		if (addr[1:0] != 2'h0) begin
			return SEL_NONE;
		end
		case (idx)
			32'(`SKEW_CTRL_IDX): return SEL_SKEW;
			32'(`FIFO_CTRL_IDX): return SEL_FIFO;
			32'(`NEG_STATUS_IDX): return SEL_NEG;
			32'(`FE_RX_CFG_IDX): return SEL_FE;
			default: return SEL_NONE;
		endcase
	endfunction

	function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] strb);
		logic [15:0] r;
		r = old;
		if (strb[0]) begin
			r[7:0] = d[7:0];
		end
		if (strb[1]) begin
			r[15:8] = d[15:8];
		end
		return r;
	endfunction

	// Link side: the sources of every crossing are registered here, so
	// the page event leaves this domain as a toggle and the rest as levels.
	always_comb begin
		l_nxt = l_r;
		l_nxt.page_rx_tgl = l_r.page_rx_tgl ^ neg_page_rx_pulse;
		l_nxt.neg_done = neg_done_in;
		l_nxt.pkt_active = rx_pkt_active;
		l_nxt.desc_locked = descrambler_locked;
		l_nxt.link_ok = link_qualified;
	end

	always_ff @(posedge link_clk) begin
		if (!link_rstn) begin
			l_r <= '0;
		end else begin
			l_r <= l_nxt;
		end
	end

	always_comb begin
		logic [15:0] m;
		reg_sel_t wsel;
		m = 16'h0;
		wsel = decode(s_r.awaddr);
		s_nxt = s_r;

		s_nxt.sync1 = l_r;
		s_nxt.sync2 = s_r.sync1;
		s_nxt.sync3 = s_r.sync2;

		// The last stage holds reset zeros until the chain has refilled, so edges
		// are only looked for after that; a toggle left high on the link side
		// across a bus reset is then not taken for a new page.
		if (s_r.warm != 2'h3) begin
			s_nxt.warm = s_r.warm + 2'h1;
		end

		// A page toggle edge sets the flag; nothing on the bus clears it.
		if (s_r.warm == 2'h3 && s_r.sync2.page_rx_tgl != s_r.sync3.page_rx_tgl) begin
			s_nxt.page_seen = 1'b1;
		end

		// Write channel: address and data are taken in either order.
		if (awvalid && s_r.awready) begin
			s_nxt.aw_have = 1'b1;
			s_nxt.awaddr = awaddr;
		end
		if (wvalid && s_r.wready) begin
			s_nxt.w_have = 1'b1;
			s_nxt.wdata = wdata;
			s_nxt.wstrb = wstrb;
		end
		if (s_r.bvalid && bready) begin
			s_nxt.bvalid = 1'b0;
		end
		if (s_r.aw_have && s_r.w_have && !s_r.bvalid) begin
			s_nxt.aw_have = 1'b0;
			s_nxt.w_have = 1'b0;
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp = `RESP_OKAY;
			case (wsel)
				SEL_SKEW: begin
					m = merge({14'h0, s_r.skew}, s_r.wdata, s_r.wstrb);
					s_nxt.skew = m[1:0];
				end
				SEL_FIFO: begin
					m = merge({11'h0, s_r.fifo, 2'h0}, s_r.wdata, s_r.wstrb);
					s_nxt.fifo = m[4:2];
				end
				SEL_NEG: begin
					// Status is read-only; the write is acknowledged and dropped.
					s_nxt.bresp = `RESP_OKAY;
				end
				SEL_FE: begin
					m = merge({4'h0, s_r.fe}, s_r.wdata, s_r.wstrb);
					s_nxt.fe = m[11:0];
					s_nxt.fe[`FE_RSVD_BIT] = 1'b0;
				end
				default: begin
					s_nxt.bresp = `RESP_DECERR;
				end
			endcase
		end
		s_nxt.awready = !s_nxt.aw_have && !s_nxt.bvalid;
		s_nxt.wready = !s_nxt.w_have && !s_nxt.bvalid;

		// Read channel: data is presented one cycle after the address.
		if (s_r.rvalid && rready) begin
			s_nxt.rvalid = 1'b0;
		end
		if (arvalid && s_r.arready) begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rresp = `RESP_OKAY;
			s_nxt.rdata = 32'h0;
			case (decode(araddr))
				SEL_SKEW: s_nxt.rdata = {30'h0, s_r.skew};
				SEL_FIFO: s_nxt.rdata = {27'h0, s_r.fifo, 2'h0};
				SEL_NEG: s_nxt.rdata = {30'h0, s_r.page_seen, s_r.sync2.neg_done};
				SEL_FE: s_nxt.rdata = {20'h0, s_r.fe};
				default: s_nxt.rresp = `RESP_DECERR;
			endcase
		end
		s_nxt.arready = !s_nxt.rvalid;

		// Packet length guard: a packet running past the limit is cut off
		// until it ends, unless the limit is switched off.
		if (s_r.sync2.pkt_active) begin
			if (s_r.pkt_cnt != 32'hffffffff) begin
				s_nxt.pkt_cnt = s_r.pkt_cnt + 32'h1;
			end
			if (s_r.pkt_cnt >= PKT_LIMIT_CYC - 1 && !s_r.fe[`FE_LIMIT_OFF_BIT]) begin
				s_nxt.cfg.rx_abort = 1'b1;
			end
		end else begin
			s_nxt.pkt_cnt = 32'h0;
			s_nxt.cfg.rx_abort = 1'b0;
		end

		// Recovery after the descrambler loses lock, in whole milliseconds.
		if (s_r.warm == 2'h3 && !s_r.sync2.desc_locked && s_r.sync3.desc_locked
				&& s_r.fe[`FE_RECOV_HI:`FE_RECOV_LO] != 4'h0) begin
			s_nxt.cfg.descrambler_recovering = 1'b1;
			s_nxt.ms_left = s_r.fe[`FE_RECOV_HI:`FE_RECOV_LO];
			s_nxt.ms_div = 32'h0;
		end else if (s_r.cfg.descrambler_recovering) begin
			if (s_r.ms_div >= MS_CYC - 1) begin
				s_nxt.ms_div = 32'h0;
				s_nxt.ms_left = s_r.ms_left - 4'h1;
				if (s_r.ms_left <= 4'h1) begin
					s_nxt.cfg.descrambler_recovering = 1'b0;
				end
			end else begin
				s_nxt.ms_div = s_r.ms_div + 32'h1;
			end
		end

		s_nxt.cfg.tx_clk_shift_en = s_r.skew[`SKEW_TX_DELAY_BIT];
		s_nxt.cfg.rx_clk_shift_en = s_r.skew[`SKEW_RX_DELAY_BIT]
			| (s_r.fifo[`FIFO_SKIP_DLY_BIT - 2] & speed_10_100);
		s_nxt.cfg.async_fifo_skip_en = s_r.fifo[`FIFO_SKIP_BIT - 2];
		s_nxt.cfg.async_fifo_skip_clock_delay_en = s_r.fifo[`FIFO_SKIP_DLY_BIT - 2];
		s_nxt.cfg.low_latency_active = s_r.fifo[`FIFO_LOW_LAT_BIT - 2] & speed_10_100;
		s_nxt.cfg.descrambler_limit_off = s_r.fe[`FE_LIMIT_OFF_BIT];
		s_nxt.cfg.descrambler_recovery_ms = s_r.fe[`FE_RECOV_HI:`FE_RECOV_LO];
		s_nxt.cfg.good_link_100 = s_r.fe[`FE_FORCE_GOOD_BIT] | s_r.sync2.link_ok;
		s_nxt.cfg.enhanced_ternary_detect_en = s_r.fe[`FE_TERNARY_BIT];
		s_nxt.cfg.enhanced_gap_detect_en = s_r.fe[`FE_GAP_BIT];
		s_nxt.cfg.scrambler_off = s_r.fe[`FE_SCRAMBLER_OFF_BIT];
		s_nxt.cfg.odd_nibble_detect_en = s_r.fe[`FE_ODD_NIBBLE_BIT];
		s_nxt.cfg.early_rx_valid_en = s_r.fe[`FE_EARLY_DV_BIT];
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_r <= '0;
			s_r.skew <= `SKEW_CTRL_RST;
			s_r.fifo <= `FIFO_CTRL_RST;
			s_r.fe <= `FE_RX_CFG_RST;
			s_r.cfg.descrambler_recovery_ms <= 4'hf;
			s_r.cfg.enhanced_ternary_detect_en <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign awready = s_r.awready;
	assign wready = s_r.wready;
	assign bvalid = s_r.bvalid;
	assign bresp = s_r.bresp;
	assign arready = s_r.arready;
	assign rvalid = s_r.rvalid;
	assign rdata = s_r.rdata;
	assign rresp = s_r.rresp;
	assign cfg = s_r.cfg;

endmodule // phy_mac_if_regs
